/* File: design/oms_edge.sv */
// Edge and level-duration detector for one pin.
// Assumes the pin is synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module oms_edge
#(
	parameter int unsigned CNT_W = 24
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic pin_i,
	input wire logic [CNT_W-1:0] low_limit_i,
	output logic rise_o,
	output logic any_o,
	output logic low_long_o
);
	typedef struct packed
	{
		logic seen;
		logic prev;
		logic [CNT_W-1:0] low_cnt;
	} oms_edge_state_t;

	oms_edge_state_t s_q;
	oms_edge_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.seen = 1'b1;
		s_d.prev = pin_i;
		if (pin_i)
		begin
			s_d.low_cnt = '0;
		end
		else if (s_q.low_cnt != low_limit_i)
		begin
			s_d.low_cnt = s_q.low_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_q <= '0;
		end
		else if (en_i)
		begin
			s_q <= s_d;
		end
	end

	// No edge until the pin has been sampled once after reset
	assign rise_o = s_q.seen & pin_i & ~s_q.prev;
	assign any_o = s_q.seen & (pin_i ^ s_q.prev);
	assign low_long_o = ~pin_i & (s_q.low_cnt == low_limit_i);
endmodule
`default_nettype wire

/* File: design/oms_sequencer.sv */
// Operating mode sequencer: OFF, BOOT, Hibernate, Standby, Active.
// Assumes all pins synchronous to clk_i; config writes come from the host
// serial engine as a whole-struct update while the bus is available.
`timescale 1ns/1ns
`default_nettype none
`include "oms_cfg.svh"
module oms_sequencer
#(
	parameter int unsigned CNT_W = `OMS_CNT_W,
	parameter int unsigned BOOT_WAIT_ONE = `OMS_BOOT_WAIT_ONE_CYC,
	parameter int unsigned BOOT_WAIT_TWO = `OMS_BOOT_WAIT_TWO_CYC,
	parameter int unsigned PULSE_ONE = `OMS_PULSE_ONE_CYC,
	parameter int unsigned PULSE_TWO = `OMS_PULSE_TWO_CYC,
	parameter int unsigned HIB_ENTRY = `OMS_HIB_ENTRY_CYC,
	parameter int unsigned MEAS_CYC = `OMS_MEAS_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic supply_ok_i,
	input wire logic boot_strap_pin_i,
	input wire logic wake_pin_i,
	input wire logic motion_detect_pin_i,
	input wire logic trigger_pin_i,
	input wire logic activity_i,
	input wire logic inactivity_i,
	input wire logic boot_done_clear_i,
	input wire oms_pkg::oms_host_t host_i,
	output oms_pkg::oms_mode_t mode_o,
	output logic bus_available_o,
	output logic sensor_enable_o,
	output logic wake_detect_enable_o,
	output logic meas_start_o,
	output logic boot_done_flag_o,
	output logic irq_pin_one_o,
	output logic irq_pin_two_o,
	output oms_pkg::oms_cfg_t cfg_o,
	output oms_pkg::oms_submode_t run_cfg_o
);
	typedef struct packed
	{
		oms_pkg::oms_mode_t mode;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] pulse_cnt;
		logic pulse_two;
		logic done;
		logic strap;
		logic meas_busy;
		oms_pkg::oms_cfg_t cfg;
	} oms_state_t;

	oms_state_t s_q;
	oms_state_t s_d;
	logic trig_rise;
	logic wake_any;
	logic mot_low_long;
	logic [CNT_W-1:0] boot_wait;

	oms_edge #(.CNT_W(CNT_W)) u_trig
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(ce_i),
		.pin_i(trigger_pin_i),
		.low_limit_i(CNT_W'(HIB_ENTRY)),
		.rise_o(trig_rise),
		.any_o(),
		.low_long_o()
	);

	oms_edge #(.CNT_W(CNT_W)) u_wake
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(ce_i),
		.pin_i(wake_pin_i),
		.low_limit_i(CNT_W'(HIB_ENTRY)),
		.rise_o(),
		.any_o(wake_any),
		.low_long_o()
	);

	oms_edge #(.CNT_W(CNT_W)) u_mot
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(ce_i),
		.pin_i(motion_detect_pin_i),
		.low_limit_i(CNT_W'(HIB_ENTRY)),
		.rise_o(),
		.any_o(),
		.low_long_o(mot_low_long)
	);

	assign boot_wait = s_q.strap ? CNT_W'(BOOT_WAIT_TWO) : CNT_W'(BOOT_WAIT_ONE);

	// Defaults differ with strap: motion defaults, pulse on pin two
	function automatic oms_pkg::oms_cfg_t dflt(input logic strap);
		oms_pkg::oms_cfg_t c;
		c = '0;
		c.boot_pulse_on_pin_two = strap;
		c.auto_wake_sleep_en = ~strap;
		return c;
	endfunction

	always_comb
	begin
		s_d = s_q;
		if (s_q.pulse_cnt != '0)
		begin
			s_d.pulse_cnt = s_q.pulse_cnt - 1'b1;
		end
		if (boot_done_clear_i)
		begin
			s_d.done = 1'b0;
		end
		if (s_q.mode != oms_pkg::OMS_OFF && s_q.mode != oms_pkg::OMS_BOOT
			&& s_q.mode != oms_pkg::OMS_HIBERNATE && host_i.cfg_we)
		begin
			s_d.cfg = host_i.cfg;
			if (s_q.strap)
			begin
				s_d.cfg.pin_two_function_select = 1'b0;
			end
		end
		case (s_q.mode)
			oms_pkg::OMS_OFF:
			begin
				s_d.cnt = '0;
				if (supply_ok_i)
				begin
					s_d.strap = boot_strap_pin_i;
					s_d.mode = oms_pkg::OMS_BOOT;
				end
			end
			oms_pkg::OMS_BOOT:
			begin
				s_d.cfg = dflt(s_q.strap);
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt >= boot_wait - 1'b1)
				begin
					s_d.cnt = '0;
					s_d.done = 1'b1;
					s_d.pulse_two = s_q.strap;
					s_d.pulse_cnt = s_q.strap ? CNT_W'(PULSE_TWO)
						: CNT_W'(PULSE_ONE);
					s_d.mode = oms_pkg::OMS_STANDBY;
					if (s_q.strap && motion_detect_pin_i)
					begin
						s_d.cfg.active = 1'b1;
						s_d.mode = oms_pkg::OMS_WAKE;
					end
				end
			end
			oms_pkg::OMS_STANDBY:
			begin
				if (!s_q.strap && s_q.cfg.hibernate_en)
				begin
					s_d.mode = oms_pkg::OMS_HIBERNATE;
				end
				else if (s_q.strap && mot_low_long)
				begin
					s_d.mode = oms_pkg::OMS_HIBERNATE;
				end
				else if (s_q.cfg.active)
				begin
					// Standby to Active clears the sleep sub-mode settings; wake_cfg is kept
					s_d.cfg.sleep_cfg = '0;
					s_d.mode = (!s_q.strap && s_q.cfg.pin_two_function_select)
						? oms_pkg::OMS_TRIG_WAIT : oms_pkg::OMS_WAKE;
				end
			end
			oms_pkg::OMS_WAKE, oms_pkg::OMS_SLEEP:
			begin
				if (!s_q.cfg.active || (s_q.strap && mot_low_long))
				begin
					s_d.cfg.active = 1'b0;
					s_d.mode = oms_pkg::OMS_STANDBY;
				end
				else if (s_q.meas_busy)
				begin
					s_d.cnt = s_q.cnt + 1'b1;
					if (s_q.cnt >= CNT_W'(MEAS_CYC - 1))
					begin
						s_d.cnt = '0;
						s_d.meas_busy = 1'b0;
						s_d.mode = oms_pkg::OMS_TRIG_WAIT;
					end
				end
				else if (s_q.cfg.auto_wake_sleep_en
					&& s_q.cfg.auto_sleep_count != '0)
				begin
					if (s_q.mode == oms_pkg::OMS_WAKE && inactivity_i)
					begin
						s_d.mode = oms_pkg::OMS_SLEEP;
					end
					else if (s_q.mode == oms_pkg::OMS_SLEEP && activity_i)
					begin
						s_d.mode = oms_pkg::OMS_WAKE;
					end
				end
			end
			oms_pkg::OMS_TRIG_WAIT:
			begin
				if (!s_q.cfg.active)
				begin
					s_d.mode = oms_pkg::OMS_STANDBY;
				end
				else if (!s_q.cfg.pin_two_function_select)
				begin
					s_d.mode = oms_pkg::OMS_WAKE;
				end
				else if (trig_rise)
				begin
					s_d.meas_busy = 1'b1;
					s_d.cnt = '0;
					s_d.mode = oms_pkg::OMS_WAKE;
				end
			end
			oms_pkg::OMS_HIBERNATE:
			begin
				// All host state lost as on supply removal
				s_d.cfg = '0;
				s_d.done = 1'b0;
				s_d.cnt = '0;
				if ((!s_q.strap && wake_any)
					|| (s_q.strap && motion_detect_pin_i))
				begin
					s_d.mode = oms_pkg::OMS_BOOT;
				end
			end
			default:
			begin
				s_d.mode = oms_pkg::OMS_OFF;
			end
		endcase
		if (!supply_ok_i)
		begin
			s_d.mode = oms_pkg::OMS_OFF;
			s_d.cfg = '0;
			s_d.done = 1'b0;
			s_d.pulse_cnt = '0;
			s_d.meas_busy = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_q <= '0;
		end
		else if (ce_i)
		begin
			s_q <= s_d;
		end
	end

	assign mode_o = s_q.mode;
	assign bus_available_o = s_q.mode == oms_pkg::OMS_STANDBY
		|| s_q.mode == oms_pkg::OMS_WAKE || s_q.mode == oms_pkg::OMS_SLEEP
		|| s_q.mode == oms_pkg::OMS_TRIG_WAIT;
	assign sensor_enable_o = s_q.mode == oms_pkg::OMS_WAKE
		|| s_q.mode == oms_pkg::OMS_SLEEP;
	assign wake_detect_enable_o = s_q.mode == oms_pkg::OMS_HIBERNATE;
	assign meas_start_o = s_q.mode == oms_pkg::OMS_TRIG_WAIT
		&& s_q.cfg.active && s_q.cfg.pin_two_function_select && trig_rise;
	assign boot_done_flag_o = s_q.done;
	assign irq_pin_one_o = (s_q.pulse_cnt != '0) && !s_q.pulse_two
		&& !s_q.cfg.boot_pulse_on_pin_two;
	assign irq_pin_two_o = (s_q.pulse_cnt != '0)
		&& (s_q.pulse_two || s_q.cfg.boot_pulse_on_pin_two);
	assign cfg_o = s_q.cfg;
	assign run_cfg_o = (s_q.mode == oms_pkg::OMS_SLEEP)
		? s_q.cfg.sleep_cfg : s_q.cfg.wake_cfg;
endmodule
`default_nettype wire

/* File: inc/oms_cfg.svh */
// Timing counts and counter width of the operating mode sequencer.
// Assumes a 100 MHz core clock; counts are in clock cycles.
`ifndef OMS_CFG_SVH
`define OMS_CFG_SVH
`define OMS_CLK_MHZ 100
`define OMS_BOOT_WAIT_ONE_US 1000
`define OMS_BOOT_WAIT_TWO_US 1000
`define OMS_PULSE_ONE_US 10
`define OMS_PULSE_TWO_US 10
`define OMS_HIB_ENTRY_US 100
`define OMS_BOOT_WAIT_ONE_CYC (`OMS_BOOT_WAIT_ONE_US * `OMS_CLK_MHZ)
`define OMS_BOOT_WAIT_TWO_CYC (`OMS_BOOT_WAIT_TWO_US * `OMS_CLK_MHZ)
`define OMS_PULSE_ONE_CYC (`OMS_PULSE_ONE_US * `OMS_CLK_MHZ)
`define OMS_PULSE_TWO_CYC (`OMS_PULSE_TWO_US * `OMS_CLK_MHZ)
`define OMS_HIB_ENTRY_CYC (`OMS_HIB_ENTRY_US * `OMS_CLK_MHZ)
`define OMS_CNT_W 24
`define OMS_MEAS_CYC 16
`endif

/* File: inc/oms_pkg.sv */
// Types of the operating mode sequencer.
// Assumes oms_cfg.svh is on the include path.
`default_nettype none
`include "oms_cfg.svh"
package oms_pkg;
	typedef enum logic [2:0]
	{
		OMS_OFF = 3'h0,
		OMS_BOOT = 3'h1,
		OMS_STANDBY = 3'h3,
		OMS_WAKE = 3'h2,
		OMS_SLEEP = 3'h6,
		OMS_TRIG_WAIT = 3'h7,
		OMS_HIBERNATE = 3'h5
	} oms_mode_t;

	typedef struct packed
	{
		logic [1:0] power_mode;
		logic [3:0] output_data_rate;
		logic flex_en;
		logic [3:0] idle_time;
		logic [3:0] decimation;
	} oms_submode_t;

	typedef struct packed
	{
		logic active;
		logic hibernate_en;
		logic pin_two_function_select;
		logic auto_wake_sleep_en;
		logic [7:0] auto_sleep_count;
		logic boot_pulse_on_pin_two;
		oms_submode_t wake_cfg;
		oms_submode_t sleep_cfg;
	} oms_cfg_t;

	typedef struct packed
	{
		logic cfg_we;
		oms_cfg_t cfg;
		logic cfg_valid;
	} oms_host_t;
endpackage
`default_nettype wire

/* File: sim/oms_chk.sv */
// Port checker of the mode sequencer, bound to its top.
// Assumes the strap pin moves only while reset is held.
`timescale 1ns/1ns
`default_nettype none
module oms_chk
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic supply_ok_i,
	input wire logic boot_strap_pin_i,
	input wire logic wake_pin_i,
	input wire oms_pkg::oms_host_t host_i,
	input wire oms_pkg::oms_mode_t mode_o,
	input wire logic bus_available_o,
	input wire logic sensor_enable_o,
	input wire logic wake_detect_enable_o,
	input wire logic meas_start_o,
	input wire logic irq_pin_one_o,
	input wire oms_pkg::oms_cfg_t cfg_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	AST_BOOT: assert property (
		mode_o == oms_pkg::OMS_OFF && supply_ok_i && ce_i |=>
		mode_o == oms_pkg::OMS_BOOT) else $error("boot");
	AST_STBY: assert property (
		mode_o == oms_pkg::OMS_STANDBY |-> bus_available_o &&
		!sensor_enable_o) else $error("standby");
	AST_HIB: assert property (
		mode_o == oms_pkg::OMS_HIBERNATE |-> wake_detect_enable_o &&
		!bus_available_o) else $error("hibernate");
	AST_PIN: assert property (
		$rose(irq_pin_one_o) |-> !boot_strap_pin_i) else $error("pin");
	AST_SEL: assert property (
		boot_strap_pin_i |-> !cfg_o.pin_two_function_select)
		else $error("select");
	AST_WR: assert property (
		host_i.cfg_we && ce_i && bus_available_o |=>
		cfg_o.wake_cfg == $past(host_i.cfg.wake_cfg)) else $error("write");
	AST_MEAS: assert property (
		meas_start_o |-> mode_o == oms_pkg::OMS_TRIG_WAIT ##1
		mode_o == oms_pkg::OMS_WAKE ##[1:20]
		mode_o == oms_pkg::OMS_TRIG_WAIT) else $error("measure");
	AST_WAKE: assert property (
		mode_o == oms_pkg::OMS_HIBERNATE && !boot_strap_pin_i && ce_i &&
		$changed(wake_pin_i) |-> ##[1:3] mode_o == oms_pkg::OMS_BOOT)
		else $error("wake");
endmodule
bind oms_sequencer oms_chk u_chk (.clk_i, .rst_n_i, .ce_i, .supply_ok_i,
	.boot_strap_pin_i, .wake_pin_i, .host_i, .mode_o, .bus_available_o,
	.sensor_enable_o, .wake_detect_enable_o, .meas_start_o,
	.irq_pin_one_o, .cfg_o);
`default_nettype wire

/* File: sim/oms_host.sv */
// Host model: control pins and whole-struct config writes.
// Assumes its tasks are called at a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module oms_host
(
	input wire logic clk_i,
	input wire logic strap_i,
	output oms_pkg::oms_host_t host_o,
	output logic wake_pin_o,
	output logic motion_o,
	output logic trig_o
);
	initial
	begin
		host_o = '0;
		wake_pin_o = 1'h1;
		motion_o = 1'h0;
		trig_o = 1'h0;
	end
	// Released data shows the inverse, never the old value
	task automatic wr(input oms_pkg::oms_cfg_t c);
		@(negedge clk_i);
		if (strap_i)
			c.pin_two_function_select = 1'h0;
		host_o = '{1'h1, c, 1'h1};
		@(negedge clk_i);
		host_o = '{1'h0, ~c, 1'h0};
	endtask
	task automatic tog();
		@(negedge clk_i);
		wake_pin_o = ~wake_pin_o;
	endtask
	task automatic lvl(input logic m);
		motion_o = m;
	endtask
	task automatic trg();
		@(negedge clk_i);
		trig_o = 1'h1;
		repeat (2) @(negedge clk_i);
		trig_o = 1'h0;
	endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench of the operating mode sequencer.
// Assumes the host model and the bound checker are compiled too.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int PW = 3;
	logic clk_i, rst_n_i, ce_i, supply_ok_i, boot_strap_pin_i, activity_i;
	logic inactivity_i, boot_done_clear_i, wake_pin_i, motion_detect_pin_i;
	logic trigger_pin_i, bus_available_o, sensor_enable_o, meas_start_o;
	logic wake_detect_enable_o, boot_done_flag_o, irq_pin_one_o;
	logic irq_pin_two_o;
	oms_pkg::oms_host_t host_i;
	oms_pkg::oms_mode_t mode_o;
	oms_pkg::oms_cfg_t cfg_o, c;
	oms_pkg::oms_submode_t run_cfg_o;
	int errors = 0;
	int tests_run = 0;
	int k;
	logic [63:0] r;
	oms_host host (.clk_i, .strap_i(boot_strap_pin_i), .host_o(host_i),
		.wake_pin_o(wake_pin_i), .motion_o(motion_detect_pin_i),
		.trig_o(trigger_pin_i));
	oms_sequencer #(.BOOT_WAIT_ONE(8), .BOOT_WAIT_TWO(8), .PULSE_ONE(PW),
		.PULSE_TWO(PW), .HIB_ENTRY(4)) dut (.clk_i, .rst_n_i,
		.ce_i, .supply_ok_i, .boot_strap_pin_i, .wake_pin_i,
		.motion_detect_pin_i, .trigger_pin_i, .activity_i, .inactivity_i,
		.boot_done_clear_i, .host_i, .mode_o, .bus_available_o,
		.sensor_enable_o, .wake_detect_enable_o, .meas_start_o,
		.boot_done_flag_o, .irq_pin_one_o, .irq_pin_two_o, .cfg_o,
		.run_cfg_o);
	initial
	begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic end_of_test();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'h1)
		begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic wm(input oms_pkg::oms_mode_t m, input int n);
		repeat (n)
			if (mode_o !== m)
				@(negedge clk_i);
		chk(mode_o === m, "mode");
		if (mode_o !== m)
			end_of_test();
	endtask
	function automatic logic [1:0] pins(input logic s);
		return s ? 2'h2 : 2'h1;
	endfunction
	task automatic pwr(input logic s, input logic m);
		rst_n_i = 1'h0;
		supply_ok_i = 1'h0;
		boot_strap_pin_i = s;
		host.lvl(m);
		repeat (12) @(negedge clk_i);
		rst_n_i = 1'h1;
		repeat (3) @(negedge clk_i);
		chk(mode_o === oms_pkg::OMS_OFF && bus_available_o === 1'h0, "off");
		supply_ok_i = 1'h1;
	endtask
	task automatic bootc(input logic s);
		logic [1:0] seen;
		int w;
		seen = 2'h0;
		w = 0;
		repeat (40)
		begin
			@(negedge clk_i);
			if ({irq_pin_two_o, irq_pin_one_o} !== 2'h0)
				w++;
			seen = seen | {irq_pin_two_o, irq_pin_one_o};
		end
		chk(seen === pins(s) && boot_done_flag_o === 1'h1, "pulse");
		chk(w == PW, "width");
	endtask
	initial
	begin
		ce_i = 1'h1;
		activity_i = 1'h0;
		inactivity_i = 1'h0;
		boot_done_clear_i = 1'h0;
		void'($urandom(32'hed51));
		pwr(1'h0, 1'h0);
		bootc(1'h0);
		wm(oms_pkg::OMS_STANDBY, 20);
		chk(cfg_o.auto_wake_sleep_en === 1'h1, "auto");
		boot_done_clear_i = 1'h1;
		@(negedge clk_i);
		boot_done_clear_i = 1'h0;
		chk(boot_done_flag_o === 1'h0, "clear");
		r = {$urandom(), $urandom()};
		c = r[$bits(c)-1:0];
		{c.active, c.hibernate_en, c.pin_two_function_select} = 3'h4;
		c.auto_wake_sleep_en = 1'h1;
		c.auto_sleep_count = 8'h01;
		c.sleep_cfg.flex_en = 1'h1;
		c.sleep_cfg.power_mode = ~c.wake_cfg.power_mode;
		ce_i = 1'h0;
		host.wr(c);
		repeat (3) @(negedge clk_i);
		chk(mode_o === oms_pkg::OMS_STANDBY, "frozen");
		ce_i = 1'h1;
		$display("test 1 done");
		host.wr(c);
		wm(oms_pkg::OMS_WAKE, 8);
		chk(sensor_enable_o === 1'h1, "sensor");
		chk(cfg_o.sleep_cfg === '0, "reset");
		host.wr(c);
		inactivity_i = 1'h1;
		wm(oms_pkg::OMS_SLEEP, 20);
		chk(run_cfg_o === c.sleep_cfg, "sleep");
		inactivity_i = 1'h0;
		activity_i = 1'h1;
		wm(oms_pkg::OMS_WAKE, 20);
		activity_i = 1'h0;
		c.active = 1'h0;
		host.wr(c);
		wm(oms_pkg::OMS_STANDBY, 8);
		chk(cfg_o === c, "kept");
		$display("test 2 done");
		c.pin_two_function_select = 1'h1;
		c.active = 1'h1;
		host.wr(c);
		wm(oms_pkg::OMS_TRIG_WAIT, 8);
		k = 0;
		fork
			host.trg();
			repeat (12)
			begin
				@(negedge clk_i);
				#1;
				if (meas_start_o === 1'h1)
					k++;
			end
		join
		chk(k == 1, "measure");
		wm(oms_pkg::OMS_TRIG_WAIT, 20);
		c.pin_two_function_select = 1'h0;
		c.active = 1'h0;
		c.hibernate_en = 1'h1;
		host.wr(c);
		wm(oms_pkg::OMS_HIBERNATE, 12);
		chk(wake_detect_enable_o === 1'h1, "detect");
		host.tog();
		wm(oms_pkg::OMS_BOOT, 4);
		bootc(1'h0);
		wm(oms_pkg::OMS_STANDBY, 20);
		chk(cfg_o.hibernate_en === 1'h0 && cfg_o !== c, "lost");
		$display("test 3 done");
		pwr(1'h1, 1'h1);
		bootc(1'h1);
		wm(oms_pkg::OMS_WAKE, 20);
		chk(cfg_o.auto_wake_sleep_en === 1'h0, "auto off");
		host.lvl(1'h0);
		wm(oms_pkg::OMS_HIBERNATE, 16);
		repeat (10) @(negedge clk_i);
		chk(mode_o === oms_pkg::OMS_HIBERNATE, "stay");
		host.lvl(1'h1);
		wm(oms_pkg::OMS_BOOT, 4);
		wm(oms_pkg::OMS_WAKE, 40);
		supply_ok_i = 1'h0;
		wm(oms_pkg::OMS_OFF, 4);
		chk(cfg_o === '0 && boot_done_flag_o === 1'h0, "supply");
		chk(bus_available_o === 1'h0, "supply bus");
		$display("test 4 done");
		end_of_test();
	end
endmodule
`default_nettype wire
